// ===== shared/acm_pkg.sv
package acm_pkg;

  // Register numbers as printed (16-bit register addresses).
  localparam logic [15:0] ADDR_MODEL_CODE = 16'h9C95;
  localparam logic [15:0] ADDR_MODEL_LENGTH = 16'h9C96;
  localparam logic [15:0] ADDR_WIRING_TYPE = 16'h9C97;
  localparam logic [15:0] ADDR_OPERATING_STATE = 16'h9C98;
  localparam logic [15:0] ADDR_GRID_CONN = 16'h9C9A;
  localparam logic [15:0] ADDR_ALARM_HI = 16'h9C9B;
  localparam logic [15:0] ADDR_ALARM_LO = 16'h9C9C;
  localparam logic [15:0] ADDR_MODE_HI = 16'h9C9D;
  localparam logic [15:0] ADDR_MODE_LO = 16'h9C9E;
  localparam logic [15:0] ADDR_ACTIVE_POWER = 16'h9C9F;
  localparam logic [15:0] ADDR_APPARENT_POWER = 16'h9CA0;
  localparam logic [15:0] ADDR_REACTIVE_POWER = 16'h9CA1;
  localparam logic [15:0] ADDR_POWER_FACTOR = 16'h9CA2;
  localparam logic [15:0] ADDR_TOTAL_CURRENT = 16'h9CA3;
  localparam logic [15:0] ADDR_AVG_VOLT_A = 16'h9CA4;
  localparam logic [15:0] ADDR_AVG_VOLT_B = 16'h9CA5;
  localparam logic [15:0] ADDR_FREQ_HI = 16'h9CA6;
  localparam logic [15:0] ADDR_FREQ_LO = 16'h9CA7;
  localparam logic [15:0] ADDR_INLET_TEMP = 16'h9CB8;
  localparam logic [15:0] ADDR_OUTLET_TEMP = 16'h9CB9;
  localparam logic [15:0] ADDR_SF_CURRENT = 16'h9D06;
  localparam logic [15:0] ADDR_SF_TEMP = 16'h9D0F;
  // First and last register of the model body, header included.
  localparam logic [15:0] ADDR_MODEL_FIRST = 16'h9C95;
  localparam logic [15:0] ADDR_MODEL_LAST = 16'h9D2F;

  // Fixed register contents.
  localparam logic [15:0] MODEL_CODE_VAL = 16'h02BD;
  localparam logic [15:0] MODEL_LENGTH_VAL = 16'h0099;
  localparam logic [15:0] SF_CURRENT_VAL = 16'hFFFF;
  localparam logic [15:0] SF_TEMP_VAL = 16'h0000;

  // Enumerated values.
  localparam logic [1:0] WIRING_SINGLE = 2'h0;
  localparam logic [1:0] WIRING_SPLIT = 2'h1;
  localparam logic [1:0] WIRING_THREE = 2'h2;
  localparam logic [15:0] STATE_OFF = 16'h0000;
  localparam logic [15:0] STATE_ON = 16'h0001;
  localparam logic [15:0] GRID_DISCONNECTED = 16'h0000;
  localparam logic [15:0] GRID_CONNECTED = 16'h0001;

  // Alarm word bit positions.
  localparam int ALM_DC_OVERVOLT = 1;
  localparam int ALM_AC_DISCONNECT = 2;
  localparam int ALM_DC_DISCONNECT = 3;
  localparam int ALM_GRID_DISCONNECT = 4;
  localparam int ALM_OVERTEMP = 7;
  localparam int ALM_OVERFREQ = 8;
  localparam int ALM_UNDERFREQ = 9;
  localparam int ALM_AC_OVERVOLT = 10;
  localparam int ALM_AC_UNDERVOLT = 11;
  localparam int ALM_MEM_LOSS_A = 12;
  localparam int ALM_MEM_LOSS_B = 14;
  localparam int ALM_MAKER = 16;
  localparam int ALARM_COUNT = 12;
  // Supported alarm bit mask.
  localparam logic [31:0] ALARM_MASK = 32'h0001_5F9E;

  // Mode word bit positions.
  localparam int MODE_GRID_FOLLOW = 0;
  localparam int MODE_GRID_FORM = 1;
  localparam logic [31:0] MODE_MASK = 32'h0000_0003;

  // Not-implemented answers per data type.
  localparam logic [15:0] NI_U16 = 16'hFFFF;
  localparam logic [15:0] NI_S16 = 16'h8000;
  localparam logic [31:0] NI_U32 = 32'hFFFF_FFFF;

  // Serial character framing.
  localparam int STOP_BITS = 1;

endpackage

// ===== design/acm_alarm_pack.sv
`timescale 1ns/10ps
// Gathers the supported alarm events into the 32-bit alarm word.
module acm_alarm_pack (
  input wire logic [acm_pkg::ALARM_COUNT-1:0] alarm_in, // Alarm event levels in bit order.
  output logic [31:0] alarm_word // Packed alarm word, unsupported bits zero.
);

  // Bit position of each event in the word.
  localparam int POS [acm_pkg::ALARM_COUNT] = '{
    acm_pkg::ALM_DC_OVERVOLT, acm_pkg::ALM_AC_DISCONNECT, acm_pkg::ALM_DC_DISCONNECT,
    acm_pkg::ALM_GRID_DISCONNECT, acm_pkg::ALM_OVERTEMP, acm_pkg::ALM_OVERFREQ,
    acm_pkg::ALM_UNDERFREQ, acm_pkg::ALM_AC_OVERVOLT, acm_pkg::ALM_AC_UNDERVOLT,
    acm_pkg::ALM_MEM_LOSS_A, acm_pkg::ALM_MEM_LOSS_B, acm_pkg::ALM_MAKER};

  // Place each event at its position; other bits stay zero.
  always_comb begin
    alarm_word = '0;
    for (int i = 0; i < acm_pkg::ALARM_COUNT; i++) begin
      alarm_word[POS[i]] = alarm_in[i];
    end
  end

endmodule // acm_alarm_pack

// ===== design/acm_register_model.sv
`timescale 1ns/10ps
// Functional notes
// - Header returns model code and length.
// - Wiring type enumerated, defaults three phase.
// - Operating state reads 0 off, 1 on.
// - Grid state reads 0 disconnected, 1 connected.
// - Alarm bits 1-4 for DC/AC/grid faults.
// - Alarm bits 7-11 for temperature/frequency/voltage.
// - Bits 12,14 memory loss, 16 maker.
// - Mode bits 0 follow, 1 form grid.
// - Total current signed, tenths ampere.
// - Average line voltage unsigned, tenths volt.
// - Inlet temperature signed whole degrees.
// - Outlet temperature shares temperature scale factor.
// - Serial link uses exactly one stop bit.
// - Unimplemented model registers return not-implemented value.
// - Current scale factor reads minus one.
// - Temperature scale factor reads zero.
//
// The register model is reached through a simple read/write port driven by the
// serial protocol engine. Measurements arrive as inputs from the converter
// control logic on the same clock and are sampled into holding registers each
// cycle, so a read returns a coherent snapshot from one edge.
//
// Every register is read-only. A write still earns an answer, with the
// refused flag set, so the protocol engine can send back an exception.
// A request with both strobes high counts as a write and loads nothing.
//
// The alarm, mode and frequency words are 32 bits wide and are read as two
// independent halves, the high half at the lower number. No latch binds
// the halves, so halves read on different cycles may come from different
// edges. A master that wants one coherent value should read both halves
// back to back to keep that window short.
//
// Unstored registers inside the model span answer all ones, whatever
// their data type. Outside the span the data reads zero and the hit flag
// stays low, so the engine can report an illegal address instead.
//
// The stop-bit count is a fixed output for the serial engine, not a
// register, and the serial engine must never offer another setting.
module acm_register_model #(
  parameter logic [1:0] WIRING_DEFAULT = acm_pkg::WIRING_THREE // Wiring type reported after reset.
) (
  // Clock and reset.
  input wire logic core_clk, // System clock, 50 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  // Register port from the serial protocol engine.
  input wire logic reg_rd, // One-cycle read request.
  input wire logic reg_wr, // One-cycle write request, always answered and refused.
  input wire logic [15:0] reg_addr, // Register number being accessed.
  input wire logic [15:0] reg_wdata, // Write data, discarded.
  output logic [15:0] reg_rdata, // Read data, valid with reg_ack.
  output logic reg_ack, // One-cycle answer to a read or write.
  output logic reg_hit, // High with reg_ack when the register is in the model.
  output logic reg_wr_refused, // High with reg_ack when a write was refused.
  // Fixed framing setting for the serial engine.
  output logic [1:0] stop_bits, // Stop bits per character for the serial engine.
  // Configuration and status levels, same clock.
  input wire logic [1:0] wiring_sel, // Wiring type from configuration.
  input wire logic wiring_sel_valid, // High when wiring_sel overrides the default.
  input wire logic unit_on, // Converter running.
  input wire logic grid_connected, // Grid contactor closed.
  input wire logic [acm_pkg::ALARM_COUNT-1:0] alarm_in, // Alarm levels, bit order as alarm word.
  input wire logic grid_following, // Operating as grid follower.
  input wire logic grid_forming, // Operating as grid former.
  // Measurements from the converter control, same clock.
  input wire logic signed [15:0] active_power_in, // Active power, 10 W units.
  input wire logic signed [15:0] apparent_power_in, // Apparent power, 10 VA units.
  input wire logic signed [15:0] reactive_power_in, // Reactive power, 10 VAR units.
  input wire logic signed [15:0] power_factor_in, // Power factor.
  input wire logic signed [15:0] total_current_in, // Sum of phase currents, 0.1 A RMS.
  input wire logic [15:0] avg_voltage_in, // Average line-to-line voltage, 0.1 V RMS.
  input wire logic [31:0] frequency_in, // Line frequency, 0.001 Hz.
  input wire logic signed [15:0] inlet_temp_in, // Inlet temperature, degrees C.
  input wire logic signed [15:0] outlet_temp_in // Outlet temperature, degrees C.
);

  // Snapshot registers of the live measurements.
  logic [15:0] wiring_r; // Reported wiring type.
  logic [15:0] op_state_r; // Reported operating state.
  logic [15:0] grid_state_r; // Reported grid connection state.
  logic [31:0] alarm_r; // Reported alarm word.
  logic [31:0] mode_r; // Reported mode word.
  logic [15:0] active_power_r; // Active power snapshot.
  logic [15:0] apparent_power_r; // Apparent power snapshot.
  logic [15:0] reactive_power_r; // Reactive power snapshot.
  logic [15:0] power_factor_r; // Power factor snapshot.
  logic [15:0] current_r; // Total current snapshot.
  logic [15:0] voltage_r; // Average voltage snapshot.
  logic [31:0] freq_r; // Frequency snapshot.
  logic [15:0] inlet_r; // Inlet temperature snapshot.
  logic [15:0] outlet_r; // Outlet temperature snapshot.

  // Read answer registers.
  logic [15:0] rdata_r; // Held read data.
  logic ack_r; // Answer strobe.
  logic hit_r; // Model hit flag.
  logic refused_r; // Write refused flag.

  // Next values of snapshots, built by combinational logic.
  logic [31:0] alarm_nxt; // Packed alarm word.
  logic [31:0] mode_nxt; // Packed mode word.
  logic [15:0] wiring_nxt; // Wiring value to report.
  logic [15:0] op_state_nxt; // Operating state value.
  logic [15:0] grid_state_nxt; // Grid state value.
  logic [15:0] rdata_nxt; // Read data for the current address.
  // Address helpers.
  logic in_model; // Address lies inside the model span.
  logic access; // Read or write taken this cycle.

  // Gather alarm events into the alarm word.
  acm_alarm_pack u_alarm_pack (
    .alarm_in(alarm_in),
    .alarm_word(alarm_nxt)
  );

  // Mode word carries only the two supported bits.
  always_comb begin
    // Start from zero so unsupported bits read zero.
    mode_nxt = '0;
    mode_nxt[acm_pkg::MODE_GRID_FOLLOW] = grid_following;
    mode_nxt[acm_pkg::MODE_GRID_FORM] = grid_forming;
  end

  // A configured wiring type replaces the default; an illegal code falls back.
  assign wiring_nxt = {14'h0000, (wiring_sel_valid && wiring_sel <= acm_pkg::WIRING_THREE) ?
                       wiring_sel : WIRING_DEFAULT};
  assign op_state_nxt = unit_on ? acm_pkg::STATE_ON : acm_pkg::STATE_OFF;
  assign grid_state_nxt = grid_connected ? acm_pkg::GRID_CONNECTED : acm_pkg::GRID_DISCONNECTED;

  // Stop-bit count is a fixed constant, with no register behind it.
  assign stop_bits = 2'(acm_pkg::STOP_BITS);

  // The span covers the header and every register that the length counts.
  assign in_model = (reg_addr >= acm_pkg::ADDR_MODEL_FIRST) && (reg_addr <= acm_pkg::ADDR_MODEL_LAST);
  // Reads and writes alike earn an answer.
  assign access = reg_rd | reg_wr;

  // Sample the measurements every clock so reads see a recent snapshot.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Wiring starts at its default; states read off until sampled.
      wiring_r <= {14'h0000, WIRING_DEFAULT};
      op_state_r <= acm_pkg::STATE_OFF;
      grid_state_r <= acm_pkg::GRID_DISCONNECTED;
      alarm_r <= '0;
      mode_r <= '0;
    end else begin
      // Take the live levels on every edge.
      wiring_r <= wiring_nxt;
      op_state_r <= op_state_nxt;
      grid_state_r <= grid_state_nxt;
      alarm_r <= alarm_nxt & acm_pkg::ALARM_MASK;
      mode_r <= mode_nxt & acm_pkg::MODE_MASK;
    end
  end

  // Power snapshots; reset to zero readings.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_power_r <= '0;
      apparent_power_r <= '0;
      reactive_power_r <= '0;
      power_factor_r <= '0;
    end else begin
      // Take the live power readings on every edge.
      active_power_r <= active_power_in;
      apparent_power_r <= apparent_power_in;
      reactive_power_r <= reactive_power_in;
      power_factor_r <= power_factor_in;
    end
  end

  // Current, voltage, frequency and temperature snapshots; reset to zero readings.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      current_r <= '0;
      voltage_r <= '0;
      freq_r <= '0;
      inlet_r <= '0;
      outlet_r <= '0;
    end else begin
      // Take the live readings on every edge.
      current_r <= total_current_in;
      voltage_r <= avg_voltage_in;
      freq_r <= frequency_in;
      inlet_r <= inlet_temp_in;
      outlet_r <= outlet_temp_in;
    end
  end

  // Address decode for reads. Wide values go out high word first.
  always_comb begin
    unique case (reg_addr)
      // Header word: model code.
      acm_pkg::ADDR_MODEL_CODE: begin
        rdata_nxt = acm_pkg::MODEL_CODE_VAL;
      end

      // Header word: registers that follow.
      acm_pkg::ADDR_MODEL_LENGTH: begin
        rdata_nxt = acm_pkg::MODEL_LENGTH_VAL;
      end

      // Wiring configuration.
      acm_pkg::ADDR_WIRING_TYPE: begin
        rdata_nxt = wiring_r;
      end

      // Converter on or off.
      acm_pkg::ADDR_OPERATING_STATE: begin
        rdata_nxt = op_state_r;
      end

      // Grid contactor state.
      acm_pkg::ADDR_GRID_CONN: begin
        rdata_nxt = grid_state_r;
      end

      // Alarm word, high half.
      acm_pkg::ADDR_ALARM_HI: begin
        rdata_nxt = alarm_r[31:16];
      end

      // Alarm word, low half.
      acm_pkg::ADDR_ALARM_LO: begin
        rdata_nxt = alarm_r[15:0];
      end

      // Mode word, high half; always zero.
      acm_pkg::ADDR_MODE_HI: begin
        rdata_nxt = mode_r[31:16];
      end

      // Mode word, low half.
      acm_pkg::ADDR_MODE_LO: begin
        rdata_nxt = mode_r[15:0];
      end

      // Active power.
      acm_pkg::ADDR_ACTIVE_POWER: begin
        rdata_nxt = active_power_r;
      end

      // Apparent power.
      acm_pkg::ADDR_APPARENT_POWER: begin
        rdata_nxt = apparent_power_r;
      end

      // Reactive power.
      acm_pkg::ADDR_REACTIVE_POWER: begin
        rdata_nxt = reactive_power_r;
      end

      // Power factor.
      acm_pkg::ADDR_POWER_FACTOR: begin
        rdata_nxt = power_factor_r;
      end

      // Total current of all phases.
      acm_pkg::ADDR_TOTAL_CURRENT: begin
        rdata_nxt = current_r;
      end

      // Average line voltage.
      acm_pkg::ADDR_AVG_VOLT_A: begin
        rdata_nxt = voltage_r;
      end

      // Second copy of the average line voltage.
      acm_pkg::ADDR_AVG_VOLT_B: begin
        rdata_nxt = voltage_r;
      end

      // Line frequency, high half.
      acm_pkg::ADDR_FREQ_HI: begin
        rdata_nxt = freq_r[31:16];
      end

      // Line frequency, low half.
      acm_pkg::ADDR_FREQ_LO: begin
        rdata_nxt = freq_r[15:0];
      end

      // Inlet temperature.
      acm_pkg::ADDR_INLET_TEMP: begin
        rdata_nxt = inlet_r;
      end

      // Outlet temperature.
      acm_pkg::ADDR_OUTLET_TEMP: begin
        rdata_nxt = outlet_r;
      end

      // Current scale factor, fixed at minus one.
      acm_pkg::ADDR_SF_CURRENT: begin
        rdata_nxt = acm_pkg::SF_CURRENT_VAL;
      end

      // Temperature scale factor, fixed at zero.
      acm_pkg::ADDR_SF_TEMP: begin
        rdata_nxt = acm_pkg::SF_TEMP_VAL;
      end

      // Other model registers are unimplemented; outside the model nothing answers data.
      default: begin
        rdata_nxt = in_model ? acm_pkg::NI_U16 : 16'h0000;
      end
    endcase
  end

  // Answer each request one cycle later; writes change nothing but are flagged.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // No answer is pending after reset.
      rdata_r <= '0;
      ack_r <= 1'b0;
      hit_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      // Every request is answered on the next edge.
      ack_r <= access;
      hit_r <= access & in_model;
      refused_r <= reg_wr;
      // Only a pure read loads new data; a write keeps the old.
      if (reg_rd && !reg_wr) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // The port outputs come straight from the answer flip-flops.
  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;
  assign reg_hit = hit_r;
  assign reg_wr_refused = refused_r;

  // Write data is never stored anywhere in this model.
  logic unused_wdata; // Collapses the discarded write data.
  assign unused_wdata = ^reg_wdata;

endmodule // acm_register_model

// ===== dv/acm_master_model.sv
`timescale 1ns/10ps
// Behavioural serial protocol engine that turns decoded frames into register requests.
module acm_master_model (
  input wire logic core_clk, // System clock.
  output logic reg_rd, // Read request.
  output logic reg_wr, // Write request.
  output logic [15:0] reg_addr, // Register number.
  output logic [15:0] reg_wdata // Write data.
);
  // Frames on the line always close with one stop bit.
  localparam int FRAME_STOP_BITS = 1;

  // Start idle so the model sees no request while it is in reset.
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // One request per frame, raised after an edge and dropped after the taking edge.
  // Writes are sent as a real master would, even though the model refuses them.
  task automatic access(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = rd;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a; // Released lines show junk, not the last value.
    reg_wdata = ~d;
  endtask
endmodule // acm_master_model

// ===== dv/acm_register_model_assertions.sv
`timescale 1ns/10ps
// Watches the register port and the framing output of the register model.
module acm_register_model_checker (
  input wire logic core_clk, // System clock.
  input wire logic reset, // Asynchronous reset.
  input wire logic reg_rd, // Read request.
  input wire logic reg_wr, // Write request.
  input wire logic [15:0] reg_addr, // Register number.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic reg_ack, // Answer strobe.
  input wire logic reg_hit, // Address inside the model.
  input wire logic reg_wr_refused, // Write refused.
  input wire logic [1:0] stop_bits // Stop bits per character.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic rd_only = reg_rd && !reg_wr; // A pure read; read with write counts as write.
  wire logic in_span = reg_addr >= acm_pkg::ADDR_MODEL_FIRST && reg_addr <= acm_pkg::ADDR_MODEL_LAST;

  a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack) else $error("No answer after a request.");
  a_ack_unasked: assert property (!(reg_rd || reg_wr) |=> !reg_ack) else $error("Answer without a request.");
  a_write_refused: assert property (reg_wr |=> reg_wr_refused) else $error("Write not refused.");
  a_read_accepted: assert property (rd_only |=> !reg_wr_refused) else $error("Read refused.");
  a_rdata_idle: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("Data moved without a read.");
  a_span_hit: assert property ((reg_rd || reg_wr) |=> reg_hit == $past(in_span)) else $error("Bad hit.");
  a_header_code: assert property (rd_only && reg_addr == acm_pkg::ADDR_MODEL_CODE |=>
    reg_rdata == 16'h02BD) else $error("Bad model code.");
  a_header_length: assert property (rd_only && reg_addr == acm_pkg::ADDR_MODEL_LENGTH |=>
    reg_rdata == 16'h0099) else $error("Bad model length.");
  a_current_scale: assert property (rd_only && reg_addr == 16'h9D06 |=> reg_rdata == 16'hFFFF)
    else $error("Bad current scale.");
  a_temp_scale: assert property (rd_only && reg_addr == 16'h9D0F |=> reg_rdata == 16'h0000)
    else $error("Bad temperature scale.");
  a_unimpl_ones: assert property (rd_only && reg_addr == 16'h9C99 |=> reg_rdata == 16'hFFFF)
    else $error("Bad unimplemented value.");
  a_alarm_unused: assert property (rd_only && reg_addr == acm_pkg::ADDR_ALARM_LO |=>
    (reg_rdata & 16'hA061) == 16'h0000) else $error("Unsupported alarm bit set.");
  a_mode_unused: assert property (rd_only && reg_addr == acm_pkg::ADDR_MODE_HI |=> reg_rdata == 16'h0000)
    else $error("Unsupported mode bit set.");
  a_wiring_range: assert property (rd_only && reg_addr == acm_pkg::ADDR_WIRING_TYPE |=>
    reg_rdata <= 16'h0002) else $error("Wiring code out of range.");
  a_stop_one: assert property (stop_bits == 2'h1) else $error("Stop bits not one.");
endmodule // acm_register_model_checker

bind acm_register_model acm_register_model_checker acm_register_model_checker_inst (.core_clk, .reset, .reg_rd,
  .reg_wr, .reg_addr, .reg_rdata, .reg_ack, .reg_hit, .reg_wr_refused, .stop_bits);

// ===== dv/tb_acm_register_model.sv
`timescale 1ns/10ps
// Drives the register model through the master model and checks each answer in order.
module tb_acm_register_model;
  typedef struct packed {logic [15:0] d; logic h; logic f;} acm_exp_s; // One expected answer.
  logic core_clk = 1'b0; // System clock.
  logic reset = 1'b1; // Reset, held at start.
  logic reg_rd, reg_wr, reg_ack, reg_hit, reg_wr_refused; // Register port strobes.
  logic [15:0] reg_addr, reg_wdata, reg_rdata; // Register port buses.
  logic [1:0] stop_bits, wiring_sel; // Framing and wiring select.
  logic wiring_sel_valid, unit_on, grid_connected, grid_following, grid_forming; // Status levels.
  logic [11:0] alarm_in; // Alarm levels.
  logic signed [15:0] active_power_in, apparent_power_in, reactive_power_in, power_factor_in; // Power.
  logic signed [15:0] total_current_in, inlet_temp_in, outlet_temp_in; // Current and temperatures.
  logic [15:0] avg_voltage_in; // Line voltage.
  logic [31:0] frequency_in, aw; // Frequency and expected alarm word.
  acm_exp_s q[$]; // Answers still to come.
  acm_exp_s e; // Answer being compared.
  logic [15:0] last_d = 16'h0000; // Read data the port should be holding.
  int miscompares = 0, num_checks = 0, seed = 62; // Counters and random seed.

  // Half period of 10 ns gives 50 MHz.
  always #10 core_clk = ~core_clk;

  acm_register_model acm_register_model_inst (.core_clk, .reset, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .reg_hit, .reg_wr_refused, .stop_bits, .wiring_sel, .wiring_sel_valid, .unit_on,
    .grid_connected, .alarm_in, .grid_following, .grid_forming, .active_power_in, .apparent_power_in,
    .reactive_power_in, .power_factor_in, .total_current_in, .avg_voltage_in, .frequency_in,
    .inlet_temp_in, .outlet_temp_in);
  acm_master_model acm_master_model_inst (.core_clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);

  // Compares one value and counts it.
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    num_checks++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  // True for addresses inside the model span.
  function automatic logic in_span(input logic [15:0] a);
    return a >= 16'h9C95 && a <= 16'h9D2F;
  endfunction

  // Packs the alarm levels into the alarm word bit positions.
  function automatic logic [31:0] alarm_word(input logic [11:0] a);
    int pos [12] = '{1, 2, 3, 4, 7, 8, 9, 10, 11, 12, 14, 16};
    alarm_word = 32'h0000_0000;
    for (int k = 0; k < 12; k++) alarm_word[pos[k]] = a[k];
  endfunction

  // A read notes its answer first, then goes out on the port.
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    q.push_back('{x, in_span(a), 1'b0});
    last_d = x;
    acm_master_model_inst.access(1'b1, 1'b0, a, 16'h0000);
  endtask

  // A write must be refused and leave the read data as it was.
  task automatic wr(input logic [15:0] a, input logic both);
    q.push_back('{last_d, in_span(a), 1'b1});
    acm_master_model_inst.access(both, 1'b1, a, 16'($random(seed)));
  endtask

  // Takes the oldest note whenever an answer appears, once it has settled.
  always @(negedge core_clk) begin
    if (reg_ack === 1'b1) begin
      if (q.size() == 0) begin
        chk("ack", 16'h0001, 16'h0000);
      end else begin
        e = q.pop_front();
        chk("rdata", reg_rdata, e.d);
        chk("hit", {15'h0, reg_hit}, {15'h0, e.h});
        chk("refused", {15'h0, reg_wr_refused}, {15'h0, e.f});
      end
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: fixed registers, refused writes, span edges, then live measurements.
  initial begin
    {wiring_sel, wiring_sel_valid, unit_on, grid_connected, grid_following, grid_forming, alarm_in} = '0;
    {active_power_in, apparent_power_in, reactive_power_in, power_factor_in} = '0;
    {total_current_in, inlet_temp_in, outlet_temp_in, avg_voltage_in, frequency_in} = '0;
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    chk("stop_bits", {14'h0, stop_bits}, 16'h0001);
    rd(acm_pkg::ADDR_WIRING_TYPE, 16'h0002);
    wr(acm_pkg::ADDR_MODEL_CODE, 1'b0);
    rd(acm_pkg::ADDR_MODEL_CODE, 16'h02BD);
    wr(acm_pkg::ADDR_MODEL_LENGTH, 1'b1);
    rd(acm_pkg::ADDR_MODEL_LENGTH, 16'h0099);
    rd(16'h9D06, 16'hFFFF);
    rd(16'h9D0F, 16'h0000);
    rd(16'h9C99, 16'hFFFF);
    rd(16'h9D2F, 16'hFFFF);
    rd(16'h9C94, 16'h0000);
    wr(16'h9D30, 1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1;
      {unit_on, grid_connected, grid_following, grid_forming, alarm_in} = 16'($random(seed));
      {active_power_in, apparent_power_in} = $random(seed);
      {reactive_power_in, power_factor_in} = $random(seed);
      {total_current_in, avg_voltage_in} = $random(seed);
      {inlet_temp_in, outlet_temp_in} = $random(seed);
      frequency_in = $random(seed);
      wiring_sel = 2'(i);
      wiring_sel_valid = ~i[2];
      if (i == 7) alarm_in = 12'hFFF;
      aw = alarm_word(alarm_in);
      repeat (2) @(posedge core_clk);
      rd(acm_pkg::ADDR_WIRING_TYPE, (wiring_sel_valid && wiring_sel <= 2'h2) ? {14'h0, wiring_sel} : 16'h0002);
      rd(acm_pkg::ADDR_OPERATING_STATE, {15'h0, unit_on});
      rd(acm_pkg::ADDR_GRID_CONN, {15'h0, grid_connected});
      rd(acm_pkg::ADDR_ALARM_HI, aw[31:16]);
      rd(acm_pkg::ADDR_ALARM_LO, aw[15:0]);
      rd(acm_pkg::ADDR_MODE_HI, 16'h0000);
      rd(acm_pkg::ADDR_MODE_LO, {14'h0, grid_forming, grid_following});
      rd(acm_pkg::ADDR_ACTIVE_POWER, active_power_in);
      rd(acm_pkg::ADDR_APPARENT_POWER, apparent_power_in);
      rd(acm_pkg::ADDR_REACTIVE_POWER, reactive_power_in);
      rd(acm_pkg::ADDR_POWER_FACTOR, power_factor_in);
      rd(acm_pkg::ADDR_TOTAL_CURRENT, total_current_in);
      rd(acm_pkg::ADDR_AVG_VOLT_A, avg_voltage_in);
      rd(acm_pkg::ADDR_AVG_VOLT_B, avg_voltage_in);
      rd(acm_pkg::ADDR_FREQ_HI, frequency_in[31:16]);
      rd(acm_pkg::ADDR_FREQ_LO, frequency_in[15:0]);
      rd(acm_pkg::ADDR_INLET_TEMP, inlet_temp_in);
      rd(acm_pkg::ADDR_OUTLET_TEMP, outlet_temp_in);
    end
    // Reset again in mid-run: read data clears and wiring falls back to three phase.
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    last_d = 16'h0000;
    wr(acm_pkg::ADDR_WIRING_TYPE, 1'b0);
    rd(acm_pkg::ADDR_WIRING_TYPE, 16'h0002);
    for (int k = 0; k < 10 && q.size() != 0; k++) @(posedge core_clk);
    if (q.size() != 0) begin
      miscompares++;
      $display("[ERR] answers expected %0d seen 0", q.size());
    end
    conclude();
  end
endmodule // tb_acm_register_model
